// ==== uart_mode_control_test.sv ====
// self-checking bench for the mode control block
// assumes umc_ctrl, its checker and the peer model are compiled
`timescale 1ns/1ps
`default_nettype none
`include "umc_cfg.svh"

module uart_mode_control_test;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_in_pin;
	logic clear_to_send_pin_n, tx_line, tx_busy, rx_room, cpu_idle;
	logic serial_out_pin, request_to_send_pin_n, rx_line, tx_permit;
	logic nine_bit_data, parity_enable, parity_odd, two_stop;
	logic sample_tick, bit_tick, irq;
	logic [4:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int fail_count, comparisons, cycles, n;

	umc_ctrl #(.ADDR_W(5)) i_umc_ctrl (.*);
	umc_peer_model i_peer (.*);

	// ==========
	// clock and hang guard
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			give_verdict();
		end
	end

	// ==========
	// helpers
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, e);
	endtask
	task rd(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata, v);
		chk(s_axi_rresp, e);
	endtask
	// clocks from one bit tick to the next
	task gap(output int c);
		c = 0;
		do @(posedge aclk); while (bit_tick !== 1'b1);
		do begin
			@(posedge aclk);
			c++;
		end while (bit_tick !== 1'b1);
	endtask
	task give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ==========
	// main sequence
	initial begin
		seed = 32'h19;
		cycles = 0;
		fail_count = 0;
		comparisons = 0;
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
		{s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		{tx_line, tx_busy, rx_room, cpu_idle} = 4'h8;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, then an unmapped place
		for (int k = 0; k < 4; k++)
			rd(5'(k * 4), 32'h0, 2'h0);
		wr(5'h10, rnd(), 2'h2);
		rd(5'h10, 32'h0, 2'h2);
		$display("test reset_map done");
		// every parity code with a random stop bit and random upper bits
		for (int k = 0; k < 4; k++) begin
			d = (rnd() & 32'hff49) | (k << 1);
			wr(5'h0, d, 2'h0);
			rd(5'h0, d & `UMC_MODE_WMASK, 2'h0);
			chk(nine_bit_data, k == 3);
			chk(parity_enable, k == 1 || k == 2);
			chk(parity_odd, k == 2);
			chk(two_stop, d[0]);
		end
		$display("test format done");
		// bit period at divisor 2 in both sample modes
		wr(5'h4, 32'h2, 2'h0);
		for (int k = 0; k < 2; k++) begin
			wr(5'h0, 32'h8000 | (k << 3), 2'h0);
			gap(n);
			gap(n);
			chk(n, k ? 12 : 48);
		end
		$display("test baud done");
		// halt in idle stops the sample ticks, divisor 2 gives one in 3
		wr(5'h0, 32'ha000, 2'h0);
		for (int k = 0; k < 2; k++) begin
			cpu_idle <= !k;
			repeat (3) @(posedge aclk);
			n = 0;
			repeat (30) begin
				@(posedge aclk);
				n += sample_tick;
			end
			chk(n, k ? 10 : 0);
		end
		$display("test idle_halt done");
		// request pin in simplex and flow modes
		for (int k = 0; k < 4; k++) begin
			wr(5'h0, 32'h8000 | ((k & 1) << 11), 2'h0);
			tx_busy <= k[1];
			rx_room <= !k[1];
			repeat (4) @(posedge aclk);
			chk(request_to_send_pin_n, k[0] ? !k[1] : k[1]);
		end
		tx_busy <= 1'b0;
		$display("test request_pin done");
		// transmit permit follows the handshake pin only in usage code 10
		for (int k = 0; k < 4; k++) begin
			wr(5'h0, 32'h8000 | ((k & 2) << 8), 2'h0);
			i_peer.hold_off(k[0]);
			repeat (4) @(posedge aclk);
			chk(tx_permit, !(k[1] && k[0]));
		end
		i_peer.hold_off(1'b0);
		$display("test permit done");
		// codec, fast mode and echo on the output pin
		for (int k = 0; k < 4; k++) begin
			d = k == 0 ? 32'h9000 : k == 1 ? 32'h9008 :
				k == 2 ? 32'h8000 : 32'h8040;
			wr(5'h0, d, 2'h0);
			tx_line <= k != 3;
			repeat (6) @(posedge aclk);
			chk(serial_out_pin, k != 0);
			if (k == 3)
				chk(rx_line, 1'b0);
		end
		tx_line <= 1'b1;
		// inverted idle level on the receive pin
		wr(5'h0, 32'h8010, 2'h0);
		i_peer.idle(1'b0);
		repeat (6) @(posedge aclk);
		chk(rx_line, 1'b1);
		i_peer.idle(1'b1);
		repeat (6) @(posedge aclk);
		chk(rx_line, 1'b0);
		wr(5'h0, 32'h8000, 2'h0);
		$display("test pin_paths done");
		// start edge wake, masked then unmasked, read clears
		wr(5'h0, 32'h8080, 2'h0);
		i_peer.send(8'hff, 8);
		repeat (8) @(posedge aclk);
		chk(irq, 1'b0);
		wr(5'hc, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b1);
		rd(5'h0, 32'h8000, 2'h0);
		rd(5'h8, 32'h1, 2'h0);
		repeat (3) @(posedge aclk);
		chk(irq, 1'b0);
		rd(5'h8, 32'h0, 2'h0);
		$display("test wake done");
		// rate measure from a sync byte at 65 clocks a bit
		wr(5'hc, 32'h2, 2'h0);
		wr(5'h0, 32'h8020, 2'h0);
		i_peer.send(8'h55, 65);
		repeat (8) @(posedge aclk);
		chk(irq, 1'b1);
		rd(5'h4, 32'h3, 2'h0);
		rd(5'h0, 32'h8000, 2'h0);
		rd(5'h8, 32'h2, 2'h0);
		$display("test auto_rate done");
		give_verdict();
	end
endmodule
`default_nettype wire

// ==== umc_baud_gen.sv ====
// baud divider: sample ticks and bit ticks with sample phase
// assumes a single clock and a synchronous active low reset
`timescale 1ns/1ps
`default_nettype none
`include "umc_cfg.svh"

module umc_baud_gen import umc_pkg::*; #(
	parameter int DIV_W = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic run,
	input wire logic fast,
	input wire logic [DIV_W-1:0] divisor,
	output logic sample_tick,
	output logic bit_tick,
	output logic [4:0] phase
);
	// ============================================================
	// counters
	logic [DIV_W-1:0] cnt_reg, cnt_next;
	logic [4:0] ph_reg, ph_next;
	logic st_reg, st_next, bt_reg, bt_next;
	logic [4:0] per_bit;

	// next state: divide clock, then count samples per bit
	always_comb begin
		per_bit = fast ? `UMC_SAMPLES_FAST : `UMC_SAMPLES_STD;
		cnt_next = cnt_reg;
		ph_next = ph_reg;
		st_next = 1'b0;
		bt_next = 1'b0;
		if (!run) begin
			cnt_next = '0;
			ph_next = '0;
		end else if (cnt_reg >= divisor) begin
			cnt_next = '0;
			st_next = 1'b1;
			if (ph_reg >= per_bit - 5'h01) begin
				ph_next = '0;
				bt_next = 1'b1;
			end else begin
				ph_next = ph_reg + 5'h01;
			end
		end else begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_reg <= '0;
			ph_reg <= '0;
			st_reg <= 1'b0;
			bt_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			ph_reg <= ph_next;
			st_reg <= st_next;
			bt_reg <= bt_next;
		end
	end

	assign sample_tick = st_reg;
	assign bit_tick = bt_reg;
	assign phase = ph_reg;
endmodule
`default_nettype wire

// ==== umc_cfg.svh ====
// register offsets, field positions, reset values and timing figures
// assumes inclusion by the package and the design modules by bare name
`ifndef UMC_CFG_SVH
`define UMC_CFG_SVH

// ============================================================
// register byte offsets
`define UMC_OFF_MODE 4'h0
`define UMC_OFF_DIV 4'h4
`define UMC_OFF_STAT 4'h8
`define UMC_OFF_MASK 4'hc

// ============================================================
// mode register field positions
`define UMC_PORT_EN 15
`define UMC_HALT_IDLE 13
`define UMC_IR_EN 12
`define UMC_RTS_MODE 11
`define UMC_USE_HI 9
`define UMC_USE_LO 8
`define UMC_WAKE 7
`define UMC_ECHO 6
`define UMC_AUTO 5
`define UMC_RX_INV 4
`define UMC_FAST 3
`define UMC_PAR_HI 2
`define UMC_PAR_LO 1
`define UMC_STOP 0

// ============================================================
// reset values and masks
`define UMC_MODE_RST 16'h0000
`define UMC_MODE_WMASK 16'hbbff
`define UMC_DIV_RST 16'h0000
`define UMC_STAT_RST 2'h0
`define UMC_MASK_RST 2'h0
`define UMC_STAT_WAKE 0
`define UMC_STAT_AUTO 1

// ============================================================
// baud and line figures
`define UMC_SAMPLES_STD 5'h10
`define UMC_SAMPLES_FAST 5'h04
`define UMC_IR_PULSE 5'h03
`define UMC_SYNC_FALLS 3'h4
`define UMC_SHIFT_STD 7
`define UMC_SHIFT_FAST 5
`define UMC_PAR_NINE 2'h3
`define UMC_PAR_ODD 2'h2
`define UMC_PAR_EVEN 2'h1
`define UMC_USE_FLOW 2'h2
`define UMC_RESP_OK 2'h0
`define UMC_RESP_ERR 2'h2

`endif

// ==== umc_ctrl.sv ====
// mode control of the serial port, with axi4-lite register slave
// assumes one clock; pins are asynchronous and pass two flip-flops
//
// Overview of operation
// - infrared codec used only when enabled
// - request pin: simplex when set, else flow
// - start edge wake interrupt, wake bit cleared on rise
// - auto rate measures 55h sync, then clears
// - invert bit makes idle receive level zero
// - fast select gives 4, else 16 samples
// - parity field selects data and parity format
// - stop select gives two or one stop
// - infrared only in 16 sample mode
`timescale 1ns/1ps
`default_nettype none
`include "umc_cfg.svh"

module umc_ctrl import umc_pkg::*; #(
	parameter int DIV_W = 16,
	parameter int ADDR_W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_in_pin,
	input wire logic clear_to_send_pin_n,
	input wire logic tx_line,
	input wire logic tx_busy,
	input wire logic rx_room,
	input wire logic cpu_idle,
	output logic serial_out_pin,
	output logic request_to_send_pin_n,
	output logic rx_line,
	output logic tx_permit,
	output logic nine_bit_data,
	output logic parity_enable,
	output logic parity_odd,
	output logic two_stop,
	output logic sample_tick,
	output logic bit_tick,
	output logic irq
);
	// ============================================================
	// helpers
	// register index from address, 4 means unmapped
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		case (a)
			ADDR_W'(`UMC_OFF_MODE): reg_sel = 3'h0;
			ADDR_W'(`UMC_OFF_DIV): reg_sel = 3'h1;
			ADDR_W'(`UMC_OFF_STAT): reg_sel = 3'h2;
			ADDR_W'(`UMC_OFF_MASK): reg_sel = 3'h3;
			default: reg_sel = 3'h4;
		endcase
	endfunction

	// merge the two low byte lanes into an old value
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// ============================================================
	// state
	logic [15:0] mode_reg, mode_next;
	logic [DIV_W-1:0] div_reg, div_next;
	logic [1:0] stat_reg, stat_next, mask_reg, mask_next;
	logic awr_reg, awr_next, bv_reg, bv_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic arr_reg, arr_next, rv_reg, rv_next;
	logic [31:0] rdata_reg, rdata_next;
	logic rx_s1_reg, rx_s2_reg, cts_s1_reg, cts_s2_reg;
	logic line_d_reg, line_d_next;
	umc_ab_state_t ab_reg, ab_next;
	logic [DIV_W+6:0] ab_cnt_reg, ab_cnt_next;
	logic [2:0] ab_falls_reg, ab_falls_next;
	logic wake_wait_reg, wake_wait_next;
	logic [4:0] ird_reg, ird_next;
	logic txo_reg, txo_next, rts_reg, rts_next, rxo_reg, rxo_next;
	logic perm_reg, perm_next, irq_reg, irq_next;
	logic [3:0] fmt_reg, fmt_next;

	// combinational terms
	logic run, ir_on, tx_enc, pin_v, src, dec, line, fall, rise;
	logic wr_go, rd_go, wake_ev, auto_ev;
	logic [2:0] wsel, rsel;
	logic [DIV_W+6:0] ab_q;
	logic [4:0] phase;
	logic [15:0] rd16;

	// ============================================================
	// baud divider
	umc_baud_gen #(
		.DIV_W(DIV_W)
	) u_baud (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(run),
		.fast(mode_reg[`UMC_FAST]),
		.divisor(div_reg),
		.sample_tick(sample_tick),
		.bit_tick(bit_tick),
		.phase(phase)
	);

	// ============================================================
	// line path: codec, echo, polarity, edges
	always_comb begin
		run = mode_reg[`UMC_PORT_EN] &
			~(mode_reg[`UMC_HALT_IDLE] & cpu_idle);
		// codec allowed only with 16 samples per bit
		ir_on = mode_reg[`UMC_IR_EN] & ~mode_reg[`UMC_FAST];
		// encoder: zero bit becomes a short high pulse
		tx_enc = ir_on ? (~tx_line & (phase < `UMC_IR_PULSE)) :
			tx_line;
		pin_v = rx_s2_reg ^ mode_reg[`UMC_RX_INV];
		src = mode_reg[`UMC_ECHO] ? tx_enc : pin_v;
		// decoder: a pulse holds the line low one bit time
		dec = ~(src | (ird_reg != 5'h00));
		line = ir_on ? dec : src;
		fall = line_d_reg & ~line;
		rise = ~line_d_reg & line;
		ird_next = ird_reg;
		if (ir_on && src) begin
			ird_next = `UMC_SAMPLES_STD;
		end else if (sample_tick && ird_reg != 5'h00) begin
			ird_next = ird_reg - 5'h01;
		end
		line_d_next = line;
	end

	// ============================================================
	// pins and datapath controls
	always_comb begin
		// idle high out while echoing or disabled
		txo_next = (run && !mode_reg[`UMC_ECHO]) ? tx_enc : 1'b1;
		if (!run) begin
			rts_next = 1'b1;
		end else if (mode_reg[`UMC_RTS_MODE]) begin
			rts_next = ~tx_busy;
		end else begin
			rts_next = ~rx_room;
		end
		perm_next = (mode_reg[`UMC_USE_HI:`UMC_USE_LO] == `UMC_USE_FLOW) ?
			~cts_s2_reg : 1'b1;
		rxo_next = line;
		fmt_next[3] = mode_reg[`UMC_PAR_HI:`UMC_PAR_LO] == `UMC_PAR_NINE;
		fmt_next[2] = (mode_reg[`UMC_PAR_HI:`UMC_PAR_LO] == `UMC_PAR_ODD) |
			(mode_reg[`UMC_PAR_HI:`UMC_PAR_LO] == `UMC_PAR_EVEN);
		fmt_next[1] = mode_reg[`UMC_PAR_HI:`UMC_PAR_LO] == `UMC_PAR_ODD;
		fmt_next[0] = mode_reg[`UMC_STOP];
	end

	// ============================================================
	// bus handshakes, register writes, hardware events
	always_comb begin
		wsel = reg_sel(s_axi_awaddr);
		rsel = reg_sel(s_axi_araddr);
		awr_next = s_axi_awvalid & s_axi_wvalid & ~awr_reg & ~bv_reg;
		wr_go = awr_reg;
		bv_next = bv_reg;
		bresp_next = bresp_reg;
		if (wr_go) begin
			bv_next = 1'b1;
			bresp_next = (wsel == 3'h4) ? `UMC_RESP_ERR : `UMC_RESP_OK;
		end else if (s_axi_bready) begin
			bv_next = 1'b0;
		end
		arr_next = s_axi_arvalid & ~arr_reg & ~rv_reg;
		rd_go = arr_reg;
		rv_next = rv_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		case (rsel)
			3'h0: rd16 = mode_reg;
			3'h1: rd16 = 16'(div_reg);
			3'h2: rd16 = {14'h0000, stat_reg};
			3'h3: rd16 = {14'h0000, mask_reg};
			default: rd16 = 16'h0000;
		endcase
		if (rd_go) begin
			rv_next = 1'b1;
			rdata_next = {16'h0000, rd16};
			rresp_next = (rsel == 3'h4) ? `UMC_RESP_ERR : `UMC_RESP_OK;
		end else if (s_axi_rready) begin
			rv_next = 1'b0;
		end

		// software writes
		mode_next = mode_reg;
		div_next = div_reg;
		mask_next = mask_reg;
		if (wr_go) begin
			case (wsel)
				3'h0: mode_next = merge16(mode_reg, s_axi_wdata, s_axi_wstrb) &
					`UMC_MODE_WMASK;
				3'h1: div_next = DIV_W'(merge16(16'(div_reg), s_axi_wdata,
					s_axi_wstrb));
				3'h3: mask_next = s_axi_wstrb[0] ? s_axi_wdata[1:0] : mask_reg;
				default: mode_next = mode_reg;
			endcase
		end

		// start edge wake: interrupt on fall, clear on next rise
		wake_ev = 1'b0;
		wake_wait_next = wake_wait_reg;
		if (!mode_reg[`UMC_WAKE]) begin
			wake_wait_next = 1'b0;
		end else if (!wake_wait_reg && fall) begin
			wake_ev = 1'b1;
			wake_wait_next = 1'b1;
		end else if (wake_wait_reg && rise) begin
			mode_next[`UMC_WAKE] = 1'b0;
			wake_wait_next = 1'b0;
		end

		// auto rate: start fall to fourth later fall is eight bits of 55h
		auto_ev = 1'b0;
		ab_next = ab_reg;
		ab_cnt_next = ab_cnt_reg;
		ab_falls_next = ab_falls_reg;
		ab_q = mode_reg[`UMC_FAST] ? (ab_cnt_reg >> `UMC_SHIFT_FAST) :
			(ab_cnt_reg >> `UMC_SHIFT_STD);
		case (ab_reg)
			UMC_AB_IDLE: begin
				if (mode_reg[`UMC_AUTO]) begin
					ab_next = UMC_AB_WAIT;
				end
			end
			UMC_AB_WAIT: begin
				ab_cnt_next = '0;
				ab_falls_next = 3'h0;
				if (!mode_reg[`UMC_AUTO]) begin
					ab_next = UMC_AB_IDLE;
				end else if (fall) begin
					ab_next = UMC_AB_MEAS;
				end
			end
			UMC_AB_MEAS: begin
				ab_cnt_next = ab_cnt_reg + 1'b1;
				if (!mode_reg[`UMC_AUTO]) begin
					ab_next = UMC_AB_IDLE;
				end else if (fall) begin
					ab_falls_next = ab_falls_reg + 3'h1;
					if (ab_falls_reg == `UMC_SYNC_FALLS - 3'h1) begin
						// measured period loads the divider, bit self clears
						div_next = (ab_q == '0) ? '0 :
							DIV_W'(ab_q - 1'b1);
						mode_next[`UMC_AUTO] = 1'b0;
						auto_ev = 1'b1;
						ab_next = UMC_AB_IDLE;
					end
				end
			end
			default: ab_next = UMC_AB_IDLE;
		endcase

		// sticky status: read clears, a new event wins
		stat_next = rd_go && rsel == 3'h2 ? 2'h0 : stat_reg;
		stat_next[`UMC_STAT_WAKE] = stat_next[`UMC_STAT_WAKE] | wake_ev;
		stat_next[`UMC_STAT_AUTO] = stat_next[`UMC_STAT_AUTO] | auto_ev;
		irq_next = |(stat_next & mask_next);
	end

	// ============================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_reg <= `UMC_MODE_RST;
			div_reg <= DIV_W'(`UMC_DIV_RST);
			stat_reg <= `UMC_STAT_RST;
			mask_reg <= `UMC_MASK_RST;
			awr_reg <= 1'b0;
			bv_reg <= 1'b0;
			bresp_reg <= `UMC_RESP_OK;
			arr_reg <= 1'b0;
			rv_reg <= 1'b0;
			rdata_reg <= 32'h00000000;
			rresp_reg <= `UMC_RESP_OK;
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			cts_s1_reg <= 1'b1;
			cts_s2_reg <= 1'b1;
			line_d_reg <= 1'b1;
			ab_reg <= UMC_AB_IDLE;
			ab_cnt_reg <= '0;
			ab_falls_reg <= 3'h0;
			wake_wait_reg <= 1'b0;
			ird_reg <= 5'h00;
			txo_reg <= 1'b1;
			rts_reg <= 1'b1;
			rxo_reg <= 1'b1;
			perm_reg <= 1'b0;
			irq_reg <= 1'b0;
			fmt_reg <= 4'h0;
		end else begin
			mode_reg <= mode_next;
			div_reg <= div_next;
			stat_reg <= stat_next;
			mask_reg <= mask_next;
			awr_reg <= awr_next;
			bv_reg <= bv_next;
			bresp_reg <= bresp_next;
			arr_reg <= arr_next;
			rv_reg <= rv_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			rx_s1_reg <= serial_in_pin;
			rx_s2_reg <= rx_s1_reg;
			cts_s1_reg <= clear_to_send_pin_n;
			cts_s2_reg <= cts_s1_reg;
			line_d_reg <= line_d_next;
			ab_reg <= ab_next;
			ab_cnt_reg <= ab_cnt_next;
			ab_falls_reg <= ab_falls_next;
			wake_wait_reg <= wake_wait_next;
			ird_reg <= ird_next;
			txo_reg <= txo_next;
			rts_reg <= rts_next;
			rxo_reg <= rxo_next;
			perm_reg <= perm_next;
			irq_reg <= irq_next;
			fmt_reg <= fmt_next;
		end
	end

	// ============================================================
	// outputs, all from flip-flops
	assign s_axi_awready = awr_reg;
	assign s_axi_wready = awr_reg;
	assign s_axi_bvalid = bv_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arr_reg;
	assign s_axi_rvalid = rv_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;
	assign serial_out_pin = txo_reg;
	assign request_to_send_pin_n = rts_reg;
	assign rx_line = rxo_reg;
	assign tx_permit = perm_reg;
	assign nine_bit_data = fmt_reg[3];
	assign parity_enable = fmt_reg[2];
	assign parity_odd = fmt_reg[1];
	assign two_stop = fmt_reg[0];
	assign irq = irq_reg;
endmodule
`default_nettype wire

// ==== umc_ctrl_checker.sv ====
// checker for the mode control block: bus and pin relations
// assumes binding into umc_ctrl, one clock, sync active low reset
`timescale 1ns/1ps
`default_nettype none

module umc_ctrl_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic tx_busy,
	input wire logic rx_room,
	input wire logic serial_out_pin,
	input wire logic request_to_send_pin_n,
	input wire logic nine_bit_data,
	input wire logic parity_enable,
	input wire logic parity_odd,
	input wire logic two_stop,
	input wire logic irq
);
	// ==========
	// bus handshake
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_AW_W_PAIR: assert property (s_axi_awready == s_axi_wready)
		else $error("write channels taken apart");
	AST_AW_TAKEN: assert property (s_axi_awready |->
		$past(s_axi_awvalid) && $past(s_axi_wvalid))
		else $error("write taken without both valids");
	AST_B_NEXT: assert property (s_axi_awready |=>
		s_axi_bvalid && !s_axi_awready)
		else $error("write response late");
	AST_R_NEXT: assert property (s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read data late");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
		!s_axi_bvalid)
		else $error("write response repeated");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid)
		else $error("read data repeated");
	// ==========
	// pins and frame format
	AST_RTS_SRC: assert property (!request_to_send_pin_n |->
		$past(tx_busy) || $past(rx_room) ||
		$past(tx_busy, 2) || $past(rx_room, 2))
		else $error("request pin low without cause");
	AST_FMT_WRITE: assert property (
		$changed({nine_bit_data, parity_enable, parity_odd, two_stop})
		|-> $past(s_axi_awready) || $past(s_axi_awready, 2))
		else $error("format changed without a write");
	AST_NINE_NOPAR: assert property (nine_bit_data |->
		!parity_enable && !parity_odd)
		else $error("nine bits with parity");
	AST_RESET_IDLE: assert property (disable iff (1'b0) !aresetn |=>
		serial_out_pin && request_to_send_pin_n && !irq && !s_axi_bvalid)
		else $error("outputs not idle after reset");
endmodule

bind umc_ctrl umc_ctrl_checker i_chk (.*);
`default_nettype wire

// ==== umc_peer_model.sv ====
// remote serial sender driving the receive pin and the handshake pin
// assumes the bench clock; frames lsb first, idle high
`timescale 1ns/1ps
`default_nettype none

module umc_peer_model (
	input wire logic aclk,
	output logic serial_in_pin,
	output logic clear_to_send_pin_n
);
	// idle line high, handshake held asserted
	initial begin
		serial_in_pin = 1'b1;
		clear_to_send_pin_n = 1'b0;
	end
	// hold a fixed line level between frames
	task idle(input logic v);
		@(posedge aclk);
		serial_in_pin <= v;
	endtask
	// move the active low handshake pin between frames
	task hold_off(input logic v);
		@(posedge aclk);
		clear_to_send_pin_n <= v;
	endtask
	// one frame: start, eight data bits, one stop, p clocks a bit
	task send(input logic [7:0] b, input int p);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge aclk);
			serial_in_pin <= f[i];
			repeat (p - 1) @(posedge aclk);
		end
	endtask
endmodule
`default_nettype wire

// ==== umc_pkg.sv ====
// types shared by the mode control block
// assumes umc_cfg.svh sits in the include path
`include "umc_cfg.svh"

package umc_pkg;
	// auto rate measure sequencer
	typedef enum logic [1:0] {
		UMC_AB_IDLE = 2'b00,
		UMC_AB_WAIT = 2'b01,
		UMC_AB_MEAS = 2'b10
	} umc_ab_state_t;
endpackage
